// >>> rtl/asf_pkg.sv
// Constants, carrier types and state encodings of the serial frame engine.
// Assumes a 20 MHz peripheral clock and an APB master with 32-bit data.
// Notes on behaviour
// - Accept 5-9 data bits, parity, 1-2 stops
// - Start low, stops high, idle line high
// - Even parity: bit set when ones odd
// - Receiver recomputes parity, flags any mismatch
// - SPI master: eight bits, order selectable, bare
// - Next frame follows at once or idles high
// - Enabled transmitter owns the serial pin
// - Buffer moves to shifter when idle or done
// - Complete flag when shifter and buffer empty
// - Empty flag gates writes to transmit buffer
// - Upper bits ignored; ninth bit written first
// - Transmitter disable waits for drain, releases pin
// - Receive from valid start to first stop
// - First stop moves frame to buffer, flags
// - Short frames read zero above; high first
// - Error flags travel with frame; low pops
// - LIN mode checks protected identifier parity only
// - Receiver disable flushes buffer and frame
// - Oversample sixteen times, eight in double speed
// - Vote samples 8-10 or 4-6 for start
// - High majority rejects start as noise
// - Every bit decided by three-sample vote
// - Low first stop sets framing error
package asf_pkg;
	// Register byte offsets
	localparam logic [4:0] OFF_RXL = 5'h00;
	localparam logic [4:0] OFF_RXH = 5'h04;
	localparam logic [4:0] OFF_TXL = 5'h08;
	localparam logic [4:0] OFF_TXH = 5'h0c;
	localparam logic [4:0] OFF_STAT = 5'h10;
	localparam logic [4:0] OFF_CTRL = 5'h14;
	localparam logic [4:0] OFF_CFG = 5'h18;
	localparam logic [4:0] OFF_BAUD = 5'h1c;
	// Status bit positions
	localparam int STAT_RXC = 0;
	localparam int STAT_TXC = 1;
	localparam int STAT_DRE = 2;
	// Oversampling and vote points
	localparam logic [4:0] SMP_NORM = 5'h10;
	localparam logic [4:0] SMP_DBL = 5'h08;
	localparam logic [4:0] VOTE_NORM = 5'h0a;
	localparam logic [4:0] VOTE_DBL = 5'h06;
	localparam logic [3:0] CHAR_BASE = 4'h5;
	localparam logic [3:0] CHAR_MAX = 4'h9;
	localparam logic [3:0] SPI_BITS = 4'h8;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	typedef struct packed {
		logic bit_order_select;
		logic two_stop;
		logic [1:0] parity_select;
		logic [2:0] char_size;
	} asf_cfg_t;
	typedef struct packed {
		logic spi_mode;
		logic one_wire;
		logic lin_mode;
		logic double_speed_setting;
		logic tx_en;
		logic rx_en;
	} asf_ctrl_t;
	typedef struct packed {
		logic framing_error_flag;
		logic rx_overrun_flag;
		logic parity_error_flag;
		logic [8:0] data;
	} asf_rx_entry_t;
	localparam asf_cfg_t CFG_RST = 7'h03;
	localparam asf_ctrl_t CTRL_RST = 6'h00;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		asf_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
		asf_rx_state_t;
endpackage

// >>> rtl/asf_tick_gen.sv
// Sample tick divider: one pulse every i_div+1 enabled clocks.
// Assumes a same-clock enable and divisor from the register file.
`timescale 1ns/1ps
module asf_tick_gen #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic [W-1:0] i_div,
	output logic o_tick
);
	logic [W-1:0] cnt_reg;

	// Count up to the divisor, pulse on wrap
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!i_run || cnt_reg >= i_div)
				cnt_reg <= '0;
			else
				cnt_reg <= cnt_reg + 1'b1;
			o_tick <= i_run && cnt_reg >= i_div;
		end
	end
endmodule

// >>> rtl/asf_rx_fifo.sv
// Receive FIFO of frames with their error flags; head is registered.
// Assumes push and pop come from the same clock domain.
`timescale 1ns/1ps
module asf_rx_fifo #(
	parameter int DEPTH = 2,
	parameter int W = 12
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_push,
	input wire logic [W-1:0] i_data,
	input wire logic i_pop,
	output logic [W-1:0] o_head,
	output logic o_valid,
	output logic o_full
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic [AW-1:0] rp_next;
	logic do_push;
	logic do_pop;

	// Accepted operations and next pointers
	assign do_push = i_push && !o_full;
	assign do_pop = i_pop && cnt_reg != '0;
	assign rp_next = rp_reg + AW'(do_pop);
	assign cnt_next = cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);

	// Storage array
	always_ff @(posedge i_clk)
	begin
		if (i_ce && do_push && !i_flush)
			mem[wp_reg] <= i_data;
	end

	// Pointers, count and registered head
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			o_head <= '0;
			o_valid <= 1'b0;
			o_full <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_flush)
			begin
				wp_reg <= '0;
				rp_reg <= '0;
				cnt_reg <= '0;
				o_head <= '0;
				o_valid <= 1'b0;
				o_full <= 1'b0;
			end
			else
			begin
				wp_reg <= wp_reg + AW'(do_push);
				rp_reg <= rp_next;
				cnt_reg <= cnt_next;
				o_valid <= cnt_next != '0;
				o_full <= cnt_next == (AW+1)'(DEPTH);
				if (do_push && cnt_reg == (AW+1)'(do_pop))
					o_head <= i_data;
				else
					o_head <= mem[rp_next];
			end
		end
	end
endmodule

// >>> rtl/asf_frame_engine.sv
// Serial frame engine: APB registers, transmitter, receiver, SPI master.
// Assumes an APB master on I_REF_CLK and an unsynchronised receive pin.
`timescale 1ns/1ps
module asf_frame_engine #(
	parameter int FIFO_DEPTH = 2
) (
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_RXD,
	output logic O_TXD,
	output logic O_TXD_OE_N,
	output logic O_XCK
);
	asf_pkg::asf_ctrl_t ctrl_reg;
	asf_pkg::asf_cfg_t cfg_reg;
	logic [15:0] baud_reg;
	logic hit, acc, wr, rd;
	logic [4:0] off;
	logic [31:0] rd_mux;
	logic rxd_s1, rxd_s2;
	logic tick;
	logic spi, par_on;
	logic [3:0] nchar;
	logic [4:0] s_n, vote_pt, half;
	logic [8:0] tx_mask;
	logic [8:0] tx_buf_reg;
	logic tx_hi_reg, tx_full_reg, txc_reg, tx_par_reg;
	logic [8:0] tx_sh_reg;
	logic [4:0] tx_ph_reg;
	logic [3:0] tx_bit_reg;
	asf_pkg::asf_tx_state_t tx_state;
	logic tx_act, tx_bend, tx_fend, tx_load;
	logic txd_reg, oe_n_reg, xck_reg;
	logic [7:0] spi_in_reg;
	logic [2:0] smp_reg;
	logic [4:0] rx_ph_reg, rx_ph_n;
	logic [3:0] rx_bit_reg;
	logic [8:0] rx_sh_reg, rx_data;
	logic rx_par_reg, vote_now, vote_bit, ovf_pend_reg;
	asf_pkg::asf_rx_state_t rx_state;
	logic rx_push, push_async, fifo_pop, fifo_valid, fifo_full;
	asf_pkg::asf_rx_entry_t rx_entry, fifo_head;
	logic pid_err, std_err;

	function automatic logic [7:0] rev8(input logic [7:0] d);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = d[7-i];
		return r;
	endfunction

	// Bus decode: one aligned word per register
	assign off = I_PADDR[4:0];
	assign hit = I_PADDR[7:5] == 3'h0 && I_PADDR[1:0] == 2'h0;
	assign acc = I_PSEL && I_PENABLE && O_PREADY;
	assign wr = acc && I_PWRITE && hit;
	assign rd = acc && !I_PWRITE && hit;
	assign fifo_pop = rd && off == asf_pkg::OFF_RXL;

	// Frame geometry from the configuration
	assign spi = ctrl_reg.spi_mode;
	assign par_on = !spi && cfg_reg.parity_select != asf_pkg::PAR_NONE;
	assign nchar = spi ? asf_pkg::SPI_BITS :
		(cfg_reg.char_size > 3'h4) ? asf_pkg::CHAR_MAX :
		asf_pkg::CHAR_BASE + {1'b0, cfg_reg.char_size};
	assign tx_mask = 9'h1ff >> (asf_pkg::CHAR_MAX - nchar);
	assign s_n = ctrl_reg.double_speed_setting ? asf_pkg::SMP_DBL :
		asf_pkg::SMP_NORM;
	assign vote_pt = ctrl_reg.double_speed_setting ? asf_pkg::VOTE_DBL :
		asf_pkg::VOTE_NORM;
	assign half = s_n >> 1;

	// Read data selection
	always_comb
	begin
		rd_mux = 32'h0;
		unique case (off)
			asf_pkg::OFF_RXL: rd_mux = {24'h0, fifo_head.data[7:0]};
			asf_pkg::OFF_RXH: rd_mux = {28'h0, fifo_head[11:8]};
			asf_pkg::OFF_STAT: rd_mux = {29'h0, !tx_full_reg, txc_reg,
				fifo_valid};
			asf_pkg::OFF_CTRL: rd_mux = {26'h0, ctrl_reg};
			asf_pkg::OFF_CFG: rd_mux = {25'h0, cfg_reg};
			asf_pkg::OFF_BAUD: rd_mux = {16'h0, baud_reg};
			default: rd_mux = 32'h0;
		endcase
	end

	// APB answer: ready in the first access cycle
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0;
			O_PSLVERR <= 1'b0;
		end
		else if (I_CE)
		begin
			O_PREADY <= I_PSEL && !I_PENABLE;
			O_PSLVERR <= I_PSEL && !I_PENABLE && !hit;
			if (I_PSEL && !I_PENABLE && !I_PWRITE && hit)
				O_PRDATA <= rd_mux;
			else
				O_PRDATA <= 32'h0;
		end
	end

	// Control, configuration and divisor registers
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			ctrl_reg <= asf_pkg::CTRL_RST;
			cfg_reg <= asf_pkg::CFG_RST;
			baud_reg <= asf_pkg::BAUD_RST;
		end
		else if (I_CE && wr)
		begin
			if (off == asf_pkg::OFF_CTRL)
				ctrl_reg <= I_PWDATA[5:0];
			if (off == asf_pkg::OFF_CFG)
				cfg_reg <= I_PWDATA[6:0];
			if (off == asf_pkg::OFF_BAUD)
				baud_reg <= I_PWDATA[15:0];
		end
	end

	// Receive pin synchroniser
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
		end
		else if (I_CE)
		begin
			rxd_s1 <= I_RXD;
			rxd_s2 <= rxd_s1;
		end
	end

	asf_tick_gen #(.W(16)) u_tick (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_ce(I_CE),
		.i_run(ctrl_reg.rx_en || tx_act),
		.i_div(baud_reg),
		.o_tick(tick)
	);

	// Transmit buffer and flags
	assign tx_act = ctrl_reg.tx_en || tx_full_reg || tx_state != asf_pkg::TX_IDLE;
	assign tx_bend = tick && tx_ph_reg >= s_n;
	assign tx_fend = tx_bend && ((tx_state == asf_pkg::TX_STOP &&
		tx_bit_reg == {3'h0, cfg_reg.two_stop}) ||
		(spi && tx_state == asf_pkg::TX_DATA && tx_bit_reg == nchar - 4'h1));
	assign tx_load = tx_full_reg && ((tx_state == asf_pkg::TX_IDLE && tick) ||
		tx_fend);
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			tx_buf_reg <= 9'h000;
			tx_hi_reg <= 1'b0;
			tx_full_reg <= 1'b0;
			txc_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			if (wr && off == asf_pkg::OFF_TXH)
				tx_hi_reg <= I_PWDATA[0];
			if (wr && off == asf_pkg::OFF_TXL && !tx_full_reg)
			begin
				tx_buf_reg <= {tx_hi_reg, I_PWDATA[7:0]};
				tx_full_reg <= 1'b1;
			end
			else if (tx_load)
				tx_full_reg <= 1'b0;
			if (tx_fend && !tx_full_reg)
				txc_reg <= 1'b1;
			else if (wr && off == asf_pkg::OFF_STAT &&
				I_PWDATA[asf_pkg::STAT_TXC])
				txc_reg <= 1'b0;
		end
	end

	// Transmit shifter and sequencer
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			tx_state <= asf_pkg::TX_IDLE;
			tx_sh_reg <= 9'h000;
			tx_ph_reg <= 5'h00;
			tx_bit_reg <= 4'h0;
			tx_par_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			if (tx_load)
			begin
				tx_sh_reg <= spi ? {1'b0, cfg_reg.bit_order_select ?
					tx_buf_reg[7:0] : rev8(tx_buf_reg[7:0])} :
					tx_buf_reg & tx_mask;
				tx_par_reg <= ^(tx_buf_reg & tx_mask) ^
					(cfg_reg.parity_select == asf_pkg::PAR_ODD);
				tx_state <= spi ? asf_pkg::TX_DATA : asf_pkg::TX_START;
				tx_ph_reg <= 5'h01;
				tx_bit_reg <= 4'h0;
			end
			else if (tick && tx_state != asf_pkg::TX_IDLE)
			begin
				tx_ph_reg <= tx_bend ? 5'h01 : tx_ph_reg + 5'h01;
				if (tx_bend)
				begin
					tx_bit_reg <= tx_bit_reg + 4'h1;
					unique case (tx_state)
						asf_pkg::TX_START:
						begin
							tx_state <= asf_pkg::TX_DATA;
							tx_bit_reg <= 4'h0;
						end
						asf_pkg::TX_DATA:
						begin
							tx_sh_reg <= tx_sh_reg >> 1;
							if (tx_bit_reg == nchar - 4'h1)
							begin
								tx_bit_reg <= 4'h0;
								tx_state <= spi ? asf_pkg::TX_IDLE :
									par_on ? asf_pkg::TX_PAR :
									asf_pkg::TX_STOP;
							end
						end
						asf_pkg::TX_PAR:
						begin
							tx_state <= asf_pkg::TX_STOP;
							tx_bit_reg <= 4'h0;
						end
						asf_pkg::TX_STOP:
						begin
							if (tx_fend)
								tx_state <= asf_pkg::TX_IDLE;
						end
						asf_pkg::TX_IDLE: tx_state <= asf_pkg::TX_IDLE;
					endcase
				end
			end
		end
	end

	// Line level, pin ownership and transfer clock
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			txd_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			xck_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			unique case (tx_state)
				asf_pkg::TX_START: txd_reg <= 1'b0;
				asf_pkg::TX_DATA: txd_reg <= tx_sh_reg[0];
				asf_pkg::TX_PAR: txd_reg <= tx_par_reg;
				asf_pkg::TX_STOP: txd_reg <= 1'b1;
				asf_pkg::TX_IDLE: txd_reg <= 1'b1;
			endcase
			oe_n_reg <= !tx_act;
			xck_reg <= spi && tx_state == asf_pkg::TX_DATA && tx_ph_reg > half;
		end
	end

	// SPI master input shifter, sampled on the rising transfer clock
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			spi_in_reg <= 8'h00;
		else if (I_CE && spi && tick && tx_state == asf_pkg::TX_DATA &&
			tx_ph_reg == half)
			spi_in_reg <= cfg_reg.bit_order_select ?
				{rxd_s2, spi_in_reg[7:1]} : {spi_in_reg[6:0], rxd_s2};
	end

	// Receive vote window and sample phase
	assign rx_ph_n = (rx_ph_reg >= s_n) ? 5'h01 : rx_ph_reg + 5'h01;
	assign vote_now = tick && rx_ph_n == vote_pt;
	assign vote_bit = (smp_reg[1] & smp_reg[0]) | (smp_reg[1] & rxd_s2) |
		(smp_reg[0] & rxd_s2);
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			smp_reg <= 3'h7;
		else if (I_CE && tick)
			smp_reg <= {smp_reg[1:0], rxd_s2};
	end

	// Receive sequencer
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			rx_state <= asf_pkg::RX_IDLE;
			rx_ph_reg <= 5'h00;
			rx_bit_reg <= 4'h0;
			rx_sh_reg <= 9'h000;
			rx_par_reg <= 1'b0;
		end
		else if (I_CE)
		begin
			if (!ctrl_reg.rx_en || spi)
				rx_state <= asf_pkg::RX_IDLE;
			else if (tick)
			begin
				rx_ph_reg <= rx_ph_n;
				unique case (rx_state)
					asf_pkg::RX_IDLE:
					begin
						if (smp_reg[0] && !rxd_s2)
						begin
							rx_state <= asf_pkg::RX_START;
							rx_ph_reg <= 5'h01;
						end
					end
					asf_pkg::RX_START:
					begin
						if (vote_now)
						begin
							rx_state <= vote_bit ? asf_pkg::RX_IDLE :
								asf_pkg::RX_DATA;
							rx_bit_reg <= 4'h0;
							rx_sh_reg <= 9'h000;
						end
					end
					asf_pkg::RX_DATA:
					begin
						if (vote_now)
						begin
							if (rx_bit_reg < nchar)
								rx_sh_reg <= {vote_bit, rx_sh_reg[8:1]};
							else
								rx_par_reg <= vote_bit;
							rx_bit_reg <= rx_bit_reg + 4'h1;
							if (rx_bit_reg == nchar - {3'h0, !par_on})
								rx_state <= asf_pkg::RX_STOP;
						end
					end
					asf_pkg::RX_STOP:
					begin
						if (vote_now)
							rx_state <= asf_pkg::RX_IDLE;
					end
				endcase
			end
		end
	end

	// Frame checks and FIFO entry
	assign rx_data = rx_sh_reg >> (asf_pkg::CHAR_MAX - nchar);
	assign pid_err = rx_data[6] != (rx_data[0] ^ rx_data[1] ^ rx_data[2] ^
		rx_data[4]) || rx_data[7] != !(rx_data[1] ^ rx_data[3] ^ rx_data[4] ^
		rx_data[5]);
	assign std_err = par_on && (rx_par_reg != (^rx_data ^
		(cfg_reg.parity_select == asf_pkg::PAR_ODD)));
	assign push_async = vote_now && rx_state == asf_pkg::RX_STOP &&
		ctrl_reg.rx_en && !spi;
	assign rx_push = push_async || (tx_fend && spi && ctrl_reg.rx_en);
	always_comb
	begin
		rx_entry = '0;
		if (spi)
			rx_entry.data = {1'b0, spi_in_reg};
		else
		begin
			rx_entry.data = rx_data;
			rx_entry.framing_error_flag = !vote_bit;
			rx_entry.parity_error_flag = ctrl_reg.lin_mode ? pid_err :
				std_err;
			rx_entry.rx_overrun_flag = ovf_pend_reg;
		end
	end

	// Lost frame marker, carried by the next stored frame
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			ovf_pend_reg <= 1'b0;
		else if (I_CE)
		begin
			if (!ctrl_reg.rx_en)
				ovf_pend_reg <= 1'b0;
			else if (rx_push)
				ovf_pend_reg <= fifo_full;
		end
	end

	asf_rx_fifo #(.DEPTH(FIFO_DEPTH), .W(12)) u_fifo (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_ce(I_CE),
		.i_flush(!ctrl_reg.rx_en),
		.i_push(rx_push),
		.i_data(rx_entry),
		.i_pop(fifo_pop),
		.o_head(fifo_head),
		.o_valid(fifo_valid),
		.o_full(fifo_full)
	);

	// Pin outputs
	assign O_TXD = txd_reg;
	assign O_TXD_OE_N = oe_n_reg;
	assign O_XCK = xck_reg;

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);

	chk_start_low: assert property (I_CE && tx_state == asf_pkg::TX_START
		|=> !txd_reg) else $error("start bit not low");
	chk_stop_high: assert property (I_CE && tx_state == asf_pkg::TX_STOP
		|=> txd_reg) else $error("stop bit not high");
	chk_pin_release: assert property (I_CE && !tx_act
		|=> O_TXD_OE_N && O_TXD) else $error("pin not released");
	chk_spi_bare: assert property (I_CE && spi && tx_load
		|=> tx_state == asf_pkg::TX_DATA) else $error("spi frame framed");
	chk_txc_set: assert property (I_CE && tx_fend && !tx_full_reg
		|=> txc_reg && tx_state == asf_pkg::TX_IDLE) else $error("no complete");
	chk_back_to_back: assert property (I_CE && tx_fend && tx_full_reg
		|=> tx_state != asf_pkg::TX_IDLE && !tx_full_reg)
		else $error("next frame not started");
	chk_rx_flush: assert property (I_CE && !ctrl_reg.rx_en
		|=> rx_state == asf_pkg::RX_IDLE && !fifo_valid)
		else $error("receiver not flushed");
	chk_noise_reject: assert property (I_CE && vote_now && vote_bit &&
		rx_state == asf_pkg::RX_START && ctrl_reg.rx_en && !spi
		|=> rx_state == asf_pkg::RX_IDLE) else $error("noise accepted");
	chk_write_guard: assert property (I_CE && wr && off ==
		asf_pkg::OFF_TXL && tx_full_reg |=> $stable(tx_buf_reg))
		else $error("full buffer overwritten");

	cov_tx_frame: cover property (tx_fend && !spi);
	cov_rx_frame: cover property (push_async && !fifo_full);
	cov_overrun: cover property (rx_push && fifo_full);
	cov_spi_frame: cover property (tx_fend && spi);
endmodule

// >>> sim/asf_remote.sv
// Remote serial port model: drives frames into the engine, captures frames.
// Assumes the engine's clock and a bit time of bit_clks clocks.
`timescale 1ns/1ps
module asf_remote (
	input wire logic i_clk,
	input wire logic i_txd,
	output logic o_rxd
);
	int bit_clks = 16;
	initial o_rxd = 1'b1;
	// Drive bits 0..n of a frame, one bit time each, then rest high
	task automatic send(input logic [12:0] v, input int n);
		for (int i = 0; i <= n; i++)
		begin
			@(posedge i_clk);
			o_rxd <= v[i];
			repeat (bit_clks - 1) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_rxd <= 1'b1;
	endtask
	// Short low pulse, too short to be a start bit
	task automatic spike(input int n);
		@(posedge i_clk);
		o_rxd <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rxd <= 1'b1;
	endtask
	// Capture the start bit plus n bits at bit centres
	task automatic take(input int n, output logic [12:0] v);
		v = '0;
		@(negedge i_txd);
		repeat (bit_clks / 2) @(posedge i_clk);
		v[0] = i_txd;
		for (int i = 1; i <= n; i++)
		begin
			repeat (bit_clks) @(posedge i_clk);
			v[i] = i_txd;
		end
	endtask
endmodule

// >>> sim/tb_asf_frame_engine.sv
// Self-checking bench of the serial frame engine over APB and the line.
// Assumes BAUD at reset, so a sample tick on every clock.
`timescale 1ns/1ps
`define CHK(n, e, s) \
	begin \
		checked++; \
		if ((s) !== (e)) \
		begin \
			err_total++; \
			$display("wrong value %s exp %h got %h", n, e, s); \
		end \
	end
module tb_asf_frame_engine;
	logic ref_clk, rstn, psel, pen, pwr, se, pready, pslverr;
	logic rxd, txd, oe_n, transfer_clock_pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [12:0] q, e;
	int err_total, checked, cyc, k;
	asf_frame_engine asf_frame_engine_i (.I_REF_CLK(ref_clk),
		.I_RSTN(rstn), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_RXD(rxd), .O_TXD(txd), .O_TXD_OE_N(oe_n), .O_XCK(transfer_clock_pin));
	asf_remote asf_remote_i (.i_clk(ref_clk), .i_txd(txd), .o_rxd(rxd));
	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Verdict and end of run
	task automatic print_verdict;
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			print_verdict();
		end
	end
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		pen <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		apb(1'b1, {3'h0, a}, d);
	endtask
	task automatic rd(input logic [4:0] a);
		apb(1'b0, {3'h0, a}, 32'h0);
	endtask
	// Poll a status bit until it is set
	task automatic poll(input int b);
		do
			rd(asf_pkg::OFF_STAT);
		while (rv[b] !== 1'b1);
	endtask
	// Expected frame in e: start, data lsb first, parity, stops
	function automatic void mk(input logic [6:0] c, input logic [8:0] v);
		int n;
		n = (c[2:0] > 4) ? 9 : int'(c[2:0]) + 5;
		e = 13'(v & 9'((1 << n) - 1)) << 1;
		k = n;
		if (c[4] ^ c[3])
		begin
			k++;
			e[k] = ^v[8:0] & 1'b0 ^ ^e[9:1] ^ c[4];
		end
		e[k + 1] = 1'b1;
		e[k + 2] = c[5];
		k = k + 1 + int'(c[5]);
	endfunction
	// Send one word through the transmitter and capture it
	task automatic tx_one(input logic [6:0] c, input logic [8:0] v);
		wr(asf_pkg::OFF_CFG, 32'(c));
		mk(c, v);
		fork
			asf_remote_i.take(k, q);
			begin
				wr(asf_pkg::OFF_TXH, 32'(v[8]));
				wr(asf_pkg::OFF_TXL, 32'(v));
			end
		join
		repeat (asf_remote_i.bit_clks) @(posedge ref_clk); // Finish last stop
		`CHK("tx frame", e, q)
	endtask
	// Read the high then the low location and compare both
	task automatic rd_pair(input logic [3:0] eh, input logic [7:0] el);
		poll(asf_pkg::STAT_RXC);
		rd(asf_pkg::OFF_RXH);
		`CHK("rx high", {28'h0, eh}, rv)
		rd(asf_pkg::OFF_RXL);
		`CHK("rx low", {24'h0, el}, rv)
	endtask
	// Remote sends one frame, x flips chosen bits
	task automatic rx_one(input logic [6:0] c, input logic [8:0] v,
		input logic [12:0] x, input logic [3:0] eh, input logic [7:0] el);
		wr(asf_pkg::OFF_CFG, 32'(c));
		mk(c, v);
		asf_remote_i.send(e ^ x, k);
		rd_pair(eh, el);
	endtask
	// Reset values, unmapped address, pin handover
	task automatic t_reset;
		`CHK("idle line", 1'b1, txd)
		`CHK("pin free", 1'b1, oe_n)
		rd(asf_pkg::OFF_STAT);
		`CHK("status", 32'h4, rv)
		rd(asf_pkg::OFF_CFG);
		`CHK("format", 32'h3, rv)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 1'b1, se)
		wr(asf_pkg::OFF_CTRL, 32'h03);
		@(posedge ref_clk);
		`CHK("pin driven", 1'b0, oe_n)
	endtask
	// Second word written as soon as the buffer is empty
	task automatic t_b2b;
		wr(asf_pkg::OFF_CFG, 32'h03);
		wr(asf_pkg::OFF_STAT, 32'h2);
		fork
			begin
				asf_remote_i.take(9, q);
				`CHK("first", 13'h034a, q)
				asf_remote_i.take(9, q);
				`CHK("second", 13'h0278, q)
			end
			begin
				wr(asf_pkg::OFF_TXL, 32'ha5);
				poll(asf_pkg::STAT_DRE);
				wr(asf_pkg::OFF_TXL, 32'h3c);
				wr(asf_pkg::OFF_TXL, 32'hff);
			end
		join
		rd(asf_pkg::OFF_STAT);
		`CHK("tx busy", 1'b0, rv[asf_pkg::STAT_TXC])
		poll(asf_pkg::STAT_TXC);
		`CHK("tx done", 1'b1, rv[asf_pkg::STAT_TXC])
		`CHK("tx empty", 1'b1, rv[asf_pkg::STAT_DRE])
	endtask
	// Disable with a word pending: pin held until drained
	task automatic t_txoff;
		int t;
		wr(asf_pkg::OFF_CFG, 32'h03);
		mk(7'h03, 9'h0f);
		fork
			asf_remote_i.take(k, q);
			begin
				wr(asf_pkg::OFF_TXL, 32'h0f);
				wr(asf_pkg::OFF_CTRL, 32'h00);
				`CHK("pin held", 1'b0, oe_n)
			end
		join
		`CHK("last frame", e, q)
		t = 0;
		while (oe_n !== 1'b1 && t < 40)
		begin
			@(posedge ref_clk);
			t++;
		end
		`CHK("pin free", 1'b1, oe_n)
		wr(asf_pkg::OFF_CTRL, 32'h03);
	endtask
	// Three frames into a two-entry buffer, then a fourth
	task automatic t_ovf;
		wr(asf_pkg::OFF_CFG, 32'h03);
		for (int i = 1; i < 4; i++)
		begin
			mk(7'h03, 9'(i * 17));
			asf_remote_i.send(e, k);
		end
		rd_pair(4'h0, 8'h11);
		rd_pair(4'h0, 8'h22);
		rd(asf_pkg::OFF_STAT);
		`CHK("drained", 1'b0, rv[asf_pkg::STAT_RXC])
		rx_one(7'h03, 9'h044, 13'h0, 4'h4, 8'h44);
	endtask
	// Receiver disable drops a stored frame
	task automatic t_flush;
		mk(7'h03, 9'h55);
		asf_remote_i.send(e, k);
		poll(asf_pkg::STAT_RXC);
		wr(asf_pkg::OFF_CTRL, 32'h02);
		rd(asf_pkg::OFF_STAT);
		`CHK("flushed", 1'b0, rv[asf_pkg::STAT_RXC])
		wr(asf_pkg::OFF_CTRL, 32'h03);
	endtask
	// Identifier parity in LIN mode, good then broken
	task automatic t_lin;
		wr(asf_pkg::OFF_CTRL, 32'h0b);
		rx_one(7'h03, 9'h080, 13'h0, 4'h0, 8'h80);
		rx_one(7'h03, 9'h080, 13'h0002, 4'h2, 8'h81);
		wr(asf_pkg::OFF_CTRL, 32'h03);
	endtask
	// Noise pulse rejected, then a real frame, both speeds
	task automatic t_noise(input logic ds);
		wr(asf_pkg::OFF_CTRL, ds ? 32'h07 : 32'h03);
		asf_remote_i.bit_clks = ds ? 8 : 16;
		asf_remote_i.spike(ds ? 2 : 4);
		repeat (20) @(posedge ref_clk);
		rx_one(7'h03, 9'h03c, 13'h0, 4'h0, 8'h3c);
		rd(asf_pkg::OFF_STAT);
		`CHK("one frame", 1'b0, rv[asf_pkg::STAT_RXC])
	endtask
	// Master serial-peripheral frame in the given bit order
	task automatic t_spi(input logic ord);
		logic [7:0] s;
		wr(asf_pkg::OFF_CTRL, 32'h23);
		wr(asf_pkg::OFF_CFG, {25'h0, ord, 6'h03});
		fork
			for (int i = 0; i < 8; i++)
			begin
				@(posedge transfer_clock_pin);
				s = {s[6:0], txd};
			end
			wr(asf_pkg::OFF_TXL, 32'h96);
		join
		`CHK("spi bits", ord ? 8'h69 : 8'h96, s)
		rd_pair(4'h0, 8'hff);
	endtask
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		tx_one(7'h2a, 9'h087);
		tx_one(7'h14, 9'h15a);
		tx_one(7'h00, 9'h0ff);
		t_b2b();
		t_txoff();
		rx_one(7'h14, 9'h1a5, 13'h0, 4'h1, 8'ha5);
		rx_one(7'h14, 9'h1a5, 13'h0400, 4'h3, 8'ha5);
		rx_one(7'h14, 9'h0a5, 13'h0800, 4'h8, 8'ha5);
		rx_one(7'h00, 9'h1f5, 13'h0, 4'h0, 8'h15);
		rx_one(7'h2a, 9'h007, 13'h0, 4'h0, 8'h07);
		t_ovf();
		t_flush();
		t_lin();
		t_noise(1'b0);
		t_noise(1'b1);
		t_spi(1'b0);
		t_spi(1'b1);
		print_verdict();
	end
endmodule
